// ===== pca_core_model.sv
// Purpose: Core side of the unit, holding the working register W
// Assumes: w_load_i is a one-cycle pulse one cycle after a control move
// Notes:   The bench presets W through set_i, as a literal move would
`timescale 1ns/1ns
module pca_core_model (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       set_i,
    input  wire logic [7:0] set_val_i,
    input  wire logic       w_load_i,
    input  wire logic [7:0] w_data_i,
    output logic      [7:0] w_o
);
    // W takes the move result first, so an exchange leaves the old value in W
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i)
            w_o <= 8'h00;
        else if (w_load_i)
            w_o <= w_data_i;
        else if (set_i)
            w_o <= set_val_i;
    end
endmodule // pca_core_model

// ===== pca_defines.vh
// Purpose: Shared constants for the port configuration access unit
// Assumes: Included by bare name from every design file
// Notes:   Selector codes are five bits; bit 4 picks direction of a control move
`ifndef PCA_DEFINES_VH
`define PCA_DEFINES_VH

// Register widths and counts
`define PCA_SEL_W          5
`define PCA_DATA_W         8
`define PCA_PORT_W         3
`define PCA_PORTS          5
`define PCA_PINS           40

// Reset values
`define PCA_MODE_RESET     5'h1F
`define PCA_CFG_RESET      8'hFF
`define PCA_PEND_RESET     8'h00
`define PCA_CMP_RESET      7'h7F
`define PCA_ZERO_BYTE      8'h00

// Selector fields
`define PCA_MODE_DIR_BIT   4
`define PCA_LIT_MSB        3

// Low-nibble selector codes
`define PCA_LO_DIR         4'hF
`define PCA_LO_PULL        4'hE
`define PCA_LO_LVL         4'hD
`define PCA_LO_ST          4'hC
`define PCA_LO_WKEN        4'hB
`define PCA_LO_WKED        4'hA
`define PCA_LO_PEND        4'h9
`define PCA_LO_CMP         4'h8
`define PCA_LO_TMR_LAST    4'h7
`define PCA_LO_TMR_WFIRST  4'h2
`define PCA_LO_TMR_CLR     4'h0

// Port indexes
`define PCA_PORT_A         3'h0
`define PCA_PORT_B         3'h1
`define PCA_PORT_C         3'h2
`define PCA_PORT_D         3'h3
`define PCA_PORT_E         3'h4

// Comparator control fields
`define PCA_CMP_EN_BIT     7
`define PCA_CMP_OE_BIT     6
`define PCA_CMP_RES_BIT    0

// Pin index of port B pin zero
`define PCA_PB0_PIN        8

`endif

// ===== pca_port_cfg.v
// Purpose: Configuration and data registers of one 8-bit port
// Assumes: Write strobes come from the decode in pca_top, same clock
// Notes:   Pin inputs are synchronised here by two flip-flops
`timescale 1ns/1ns
`include "pca_defines.vh"

module pca_port_cfg #(
    parameter HAS_SCHMITT = 1
) (
    input  wire       clk_sys_i,
    input  wire       reset_i,
    input  wire       ce_i,
    input  wire       wr_dir_i,
    input  wire       wr_pull_i,
    input  wire       wr_lvl_i,
    input  wire       wr_st_i,
    input  wire       wr_data_i,
    input  wire [7:0] wdata_i,
    input  wire [7:0] pin_in_i,
    output reg  [7:0] direction_o,
    output reg  [7:0] pullup_disable_o,
    output reg  [7:0] input_level_o,
    output reg  [7:0] schmitt_disable_o,
    output reg  [7:0] data_o,
    output reg  [7:0] pin_sync_o
);

    reg [7:0] pin_meta;

    // Two-stage synchroniser; only the second stage is read
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pin_meta   <= `PCA_ZERO_BYTE;
            pin_sync_o <= `PCA_ZERO_BYTE;
        end else if (ce_i) begin
            pin_meta   <= pin_in_i;
            pin_sync_o <= pin_meta;
        end
    end

    // Configuration registers, all ones after reset
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            direction_o       <= `PCA_CFG_RESET;
            pullup_disable_o  <= `PCA_CFG_RESET;
            input_level_o     <= `PCA_CFG_RESET;
            schmitt_disable_o <= `PCA_CFG_RESET;
        end else if (ce_i) begin
            if (wr_dir_i) begin
                direction_o <= wdata_i;
            end
            if (wr_pull_i) begin
                pullup_disable_o <= wdata_i;
            end
            if (wr_lvl_i) begin
                input_level_o <= wdata_i;
            end
            // Schmitt write, ports B to E
            if (wr_st_i && (HAS_SCHMITT != 0)) begin
                schmitt_disable_o <= wdata_i;
            end
        end
    end

    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            data_o <= `PCA_ZERO_BYTE;
        end else if (ce_i && wr_data_i) begin
            data_o <= wdata_i;
        end
    end

endmodule // pca_port_cfg

// ===== pca_top.v
// Purpose: Selector-driven access to port control and timer registers
// Assumes: Core strobes are one-cycle pulses on clk_sys_i; timers sit outside
// Notes:   Comparator analog path and wake-up sequencing live outside
// Functional notes
// - Literal loads four bits, W five bits
// - Bit 4 picks read or write
// - Comparator and pending always exchange with W
// - Edge and enable registers always written
// - Selector holds until reloaded
// - Selector resets to 1Fh
// - Timer one via B, two via C
// - Each move touches only its port
// - Direction one is input, zero output
// - Pull-up one disconnects, zero connects
// - Level one TTL unless Schmitt enabled, zero CMOS
// - Schmitt zero enables, ports B to E
// - Wake-up enable zero enables pin
// - Edge zero rising, one falling
// - Pending set by valid wake-up edge
// - Comparator enable, output, result bits
// - Control registers reset to FFh, except pending (00h)
// - Read source selects data register
// - Input pin data write still stored
`timescale 1ns/1ns
`include "pca_defines.vh"

module pca_top (
    input  wire        clk_sys_i,
    input  wire        reset_i,
    input  wire        ce_i,
    input  wire        mode_lit_load_i,
    input  wire        mode_w_load_i,
    input  wire [7:0]  w_i,
    output reg  [4:0]  mode_o,
    input  wire        ctrl_move_i,
    input  wire [2:0]  ctrl_port_i,
    output reg         w_load_o,
    output reg  [7:0]  w_data_o,
    input  wire        data_wr_i,
    input  wire        data_rd_i,
    input  wire [2:0]  data_port_i,
    output reg         rd_valid_o,
    output reg  [7:0]  rd_data_o,
    input  wire        port_read_source_i,
    output wire        timer_rd_o,
    output wire        timer_wr_o,
    output wire        timer_clr_o,
    output wire        timer_sel_o,
    output wire [2:0]  timer_addr_o,
    output wire [7:0]  timer_wdata_o,
    input  wire [7:0]  timer_rdata_i,
    input  wire        comparator_result_i,
    output wire        comparator_enable_o,
    output wire [7:0]  wakeup_pending_o,
    input  wire [39:0] pin_in_i,
    output reg  [39:0] pin_out_o,
    output reg  [39:0] pin_oe_o,
    output reg  [39:0] pullup_en_o,
    output reg  [39:0] level_ttl_o,
    output reg  [39:0] schmitt_en_o
);

    // Selector fields
    wire [3:0]  sel_lo;
    wire        sel_write;
    // Per-port views of the configuration banks
    wire [39:0] dir_all;
    wire [39:0] pull_all;
    wire [39:0] lvl_all;
    wire [39:0] st_all;
    wire [39:0] data_all;
    wire [39:0] sync_all;
    wire [4:0]  port_hit;
    wire [4:0]  data_hit;
    // Decoded move kinds
    reg         do_cfg_wr;
    reg         do_cfg_rd;
    reg         do_tmr_rd;
    reg         do_tmr_wr;
    reg         do_tmr_clr;
    reg         do_cmp_x;
    reg         do_pend_x;
    reg         do_wked_wr;
    reg         do_wken_wr;
    reg  [7:0]  cfg_rd_value;
    // Port B wake-up and comparator state
    reg  [7:0]  wakeup_enable_low;
    reg  [7:0]  wakeup_edge_select;
    reg  [7:0]  wakeup_pending_flags;
    reg  [6:0]  comparator_control;
    reg  [7:0]  pb_prev;
    reg  [7:0]  wake_event;
    reg         cmp_meta;
    reg         cmp_sync;
    wire [7:0]  cmp_full;
    wire [7:0]  pb_sync;
    reg  [7:0]  next_pending;
    reg  [7:0]  next_w_data;
    reg         next_w_load;
    reg  [7:0]  sel_data;
    reg  [7:0]  sel_pins;
    integer     i_rd, i_wk, i_mux;

    assign sel_lo    = mode_o[3:0];
    assign sel_write = mode_o[`PCA_MODE_DIR_BIT];

    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            mode_o <= `PCA_MODE_RESET;
        end else if (ce_i) begin
            if (mode_w_load_i) begin
                mode_o <= w_i[`PCA_SEL_W-1:0];
            end else if (mode_lit_load_i) begin
                mode_o <= {mode_o[`PCA_MODE_DIR_BIT], w_i[`PCA_LIT_MSB:0]};
            end
        end
    end

    // Move decode; unmapped combinations leave every strobe low, except do_cfg_wr and do_cfg_rd for config selectors on ports 5 to 7
    always @* begin
        do_cfg_wr  = 1'b0;
        do_cfg_rd  = 1'b0;
        do_tmr_rd  = 1'b0;
        do_tmr_wr  = 1'b0;
        do_tmr_clr = 1'b0;
        do_cmp_x   = 1'b0;
        do_pend_x  = 1'b0;
        do_wked_wr = 1'b0;
        do_wken_wr = 1'b0;
        if (ctrl_move_i) begin
            case (sel_lo)
                `PCA_LO_DIR, `PCA_LO_PULL, `PCA_LO_LVL: begin
                    do_cfg_wr = sel_write;
                    do_cfg_rd = ~sel_write;
                end
                `PCA_LO_ST: begin
                    do_cfg_wr = sel_write && (ctrl_port_i != `PCA_PORT_A);
                    do_cfg_rd = ~sel_write && (ctrl_port_i != `PCA_PORT_A);
                end
                `PCA_LO_CMP: begin
                    do_cmp_x = (ctrl_port_i == `PCA_PORT_B);
                end
                `PCA_LO_PEND: begin
                    do_pend_x = (ctrl_port_i == `PCA_PORT_B);
                end
                `PCA_LO_WKED: begin
                    do_wked_wr = (ctrl_port_i == `PCA_PORT_B);
                end
                `PCA_LO_WKEN: begin
                    do_wken_wr = (ctrl_port_i == `PCA_PORT_B);
                end
                default: begin
                    if ((ctrl_port_i == `PCA_PORT_B) || (ctrl_port_i == `PCA_PORT_C)) begin
                        do_tmr_rd  = ~sel_write;
                        do_tmr_clr = sel_write && (sel_lo == `PCA_LO_TMR_CLR);
                        do_tmr_wr  = sel_write && (sel_lo >= `PCA_LO_TMR_WFIRST);
                    end
                end
            endcase
        end
    end

    // Timer strobes are combinational so read data lands in the same cycle
    assign timer_rd_o    = ce_i & do_tmr_rd;
    assign timer_wr_o    = ce_i & do_tmr_wr;
    assign timer_clr_o   = ce_i & do_tmr_clr;
    assign timer_sel_o   = (ctrl_port_i == `PCA_PORT_C);
    assign timer_addr_o  = sel_lo[2:0];
    assign timer_wdata_o = w_i;

    genvar g;
    generate
        for (g = 0; g < `PCA_PORTS; g = g + 1) begin : g_port
            assign port_hit[g] = (ctrl_port_i == g);
            assign data_hit[g] = (data_port_i == g);
            pca_port_cfg #(
                .HAS_SCHMITT (g != 0)
            ) u_cfg (
                .clk_sys_i         (clk_sys_i),
                .reset_i           (reset_i),
                .ce_i              (ce_i),
                .wr_dir_i          (do_cfg_wr & port_hit[g] & (sel_lo == `PCA_LO_DIR)),
                .wr_pull_i         (do_cfg_wr & port_hit[g] & (sel_lo == `PCA_LO_PULL)),
                .wr_lvl_i          (do_cfg_wr & port_hit[g] & (sel_lo == `PCA_LO_LVL)),
                .wr_st_i           (do_cfg_wr & port_hit[g] & (sel_lo == `PCA_LO_ST)),
                .wr_data_i         (data_wr_i & data_hit[g]),
                .wdata_i           (w_i),
                .pin_in_i          (pin_in_i[g*8 +: 8]),
                .direction_o       (dir_all[g*8 +: 8]),
                .pullup_disable_o  (pull_all[g*8 +: 8]),
                .input_level_o     (lvl_all[g*8 +: 8]),
                .schmitt_disable_o (st_all[g*8 +: 8]),
                .data_o            (data_all[g*8 +: 8]),
                .pin_sync_o        (sync_all[g*8 +: 8])
            );
        end
    endgenerate

    // Read-back of the selected port's configuration byte
    always @* begin
        cfg_rd_value = `PCA_ZERO_BYTE;
        for (i_rd = 0; i_rd < `PCA_PORTS; i_rd = i_rd + 1) begin
            if (ctrl_port_i == i_rd) begin
                case (sel_lo)
                    `PCA_LO_DIR:  cfg_rd_value = dir_all[i_rd*8 +: 8];
                    `PCA_LO_PULL: cfg_rd_value = pull_all[i_rd*8 +: 8];
                    `PCA_LO_LVL:  cfg_rd_value = lvl_all[i_rd*8 +: 8];
                    `PCA_LO_ST:   cfg_rd_value = st_all[i_rd*8 +: 8];
                    default:      cfg_rd_value = `PCA_ZERO_BYTE;
                endcase
            end
        end
    end

    // Comparator result passes two flip-flops before use
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else if (ce_i) begin
            cmp_meta <= comparator_result_i;
            cmp_sync <= cmp_meta;
        end
    end

    assign cmp_full = {comparator_control, cmp_sync};
    assign comparator_enable_o = ~comparator_control[`PCA_CMP_EN_BIT-1];
    assign pb_sync = sync_all[15:8];

    always @* begin
        for (i_wk = 0; i_wk < `PCA_DATA_W; i_wk = i_wk + 1) begin
            if (wakeup_edge_select[i_wk]) begin
                wake_event[i_wk] = ~wakeup_enable_low[i_wk] & pb_prev[i_wk] & ~pb_sync[i_wk];
            end else begin
                wake_event[i_wk] = ~wakeup_enable_low[i_wk] & ~pb_prev[i_wk] & pb_sync[i_wk];
            end
        end
    end

    // edge sets pending, set beats exchange clear
    always @* begin
        next_pending = wakeup_pending_flags;
        if (do_pend_x) begin
            next_pending = w_i;
        end
        next_pending = next_pending | wake_event;
    end

    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wakeup_enable_low    <= `PCA_CFG_RESET;
            wakeup_edge_select   <= `PCA_CFG_RESET;
            wakeup_pending_flags <= `PCA_PEND_RESET;
            comparator_control   <= `PCA_CMP_RESET;
            pb_prev              <= `PCA_ZERO_BYTE;
        end else if (ce_i) begin
            pb_prev              <= pb_sync;
            wakeup_pending_flags <= next_pending;
            if (do_wken_wr) begin
                wakeup_enable_low <= w_i;
            end
            if (do_wked_wr) begin
                wakeup_edge_select <= w_i;
            end
            if (do_cmp_x) begin
                comparator_control <= w_i[7:1];
            end
        end
    end

    assign wakeup_pending_o = wakeup_pending_flags;

    // Value returned to W; exchanges return the old contents
    always @* begin
        next_w_load = 1'b0;
        next_w_data = w_data_o;
        if (do_cfg_rd && (ctrl_port_i <= `PCA_PORT_E)) begin
            next_w_load = 1'b1;
            next_w_data = cfg_rd_value;
        end else if (do_tmr_rd) begin
            next_w_load = 1'b1;
            next_w_data = timer_rdata_i;
        end else if (do_cmp_x) begin
            next_w_load = 1'b1;
            next_w_data = cmp_full;
        end else if (do_pend_x) begin
            next_w_load = 1'b1;
            next_w_data = wakeup_pending_flags;
        end
    end

    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            w_load_o <= 1'b0;
            w_data_o <= `PCA_ZERO_BYTE;
        end else if (ce_i) begin
            w_load_o <= next_w_load;
            w_data_o <= next_w_data;
        end
    end

    always @* begin
        sel_data = `PCA_ZERO_BYTE;
        sel_pins = `PCA_ZERO_BYTE;
        for (i_mux = 0; i_mux < `PCA_PORTS; i_mux = i_mux + 1) begin
            if (data_port_i == i_mux) begin
                sel_data = data_all[i_mux*8 +: 8];
                sel_pins = sync_all[i_mux*8 +: 8];
            end
        end
    end

    // Port data read answers one cycle after the strobe
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= `PCA_ZERO_BYTE;
        end else if (ce_i) begin
            rd_valid_o <= data_rd_i;
            if (data_rd_i) begin
                rd_data_o <= port_read_source_i ? sel_data : sel_pins;
            end
        end
    end

    // comparator output on port B pin zero
    // Pin controls are registered so the pads see glitch-free levels
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pin_out_o    <= {`PCA_PINS{1'b0}};
            pin_oe_o     <= {`PCA_PINS{1'b0}};
            pullup_en_o  <= {`PCA_PINS{1'b0}};
            level_ttl_o  <= {`PCA_PINS{1'b1}};
            schmitt_en_o <= {`PCA_PINS{1'b0}};
        end else if (ce_i) begin
            pin_out_o <= data_all;
            pin_oe_o  <= ~dir_all;
            if (~comparator_control[`PCA_CMP_EN_BIT-1] &&
                ~comparator_control[`PCA_CMP_OE_BIT-1]) begin
                pin_out_o[`PCA_PB0_PIN] <= cmp_sync;
                pin_oe_o[`PCA_PB0_PIN]  <= 1'b1;
            end
            pullup_en_o  <= ~pull_all;
            level_ttl_o  <= lvl_all & st_all;
            schmitt_en_o <= {~st_all[39:8], 8'h00};
        end
    end

endmodule // pca_top

// ===== pca_top_bench.sv
// Purpose: Self-checking bench for the port configuration access unit
// Assumes: Core model holds W; the bench stands in for both timers
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module pca_top_bench;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        mode_lit_load_i = 1'b0;
    logic        mode_w_load_i = 1'b0;
    logic        ctrl_move_i = 1'b0;
    logic [2:0]  ctrl_port_i = 3'h0;
    logic        data_wr_i = 1'b0;
    logic        data_rd_i = 1'b0;
    logic [2:0]  data_port_i = 3'h0;
    logic        port_read_source_i = 1'b0;
    logic        comparator_result_i = 1'b1;
    logic [39:0] pin_in_i = 40'h5A3C9600C3;
    logic        set_w = 1'b0;
    logic [7:0]  set_val = 8'h00;
    integer      miscompares = 0;
    integer      cmp_count = 0;
    integer      cyc = 0;
    wire  [7:0]  w_i, w_data_o, rd_data_o, timer_wdata_o, timer_rdata_i, wakeup_pending_o;
    wire  [4:0]  mode_o;
    wire  [2:0]  timer_addr_o;
    wire         w_load_o, rd_valid_o, timer_rd_o, timer_wr_o, timer_clr_o, timer_sel_o;
    wire         comparator_enable_o;
    wire  [39:0] pin_out_o, pin_oe_o, pullup_en_o, level_ttl_o, schmitt_en_o;

    // Timer stand-in: read data encodes which timer and byte was asked for
    assign timer_rdata_i = {4'h6, timer_sel_o, timer_addr_o};

    pca_top u_dut (.clk_sys_i, .reset_i, .ce_i, .mode_lit_load_i, .mode_w_load_i, .w_i,
        .mode_o, .ctrl_move_i, .ctrl_port_i, .w_load_o, .w_data_o, .data_wr_i, .data_rd_i,
        .data_port_i, .rd_valid_o, .rd_data_o, .port_read_source_i, .timer_rd_o, .timer_wr_o,
        .timer_clr_o, .timer_sel_o, .timer_addr_o, .timer_wdata_o, .timer_rdata_i,
        .comparator_result_i, .comparator_enable_o, .wakeup_pending_o, .pin_in_i, .pin_out_o,
        .pin_oe_o, .pullup_en_o, .level_ttl_o, .schmitt_en_o);
    pca_core_model u_core (.clk_sys_i, .reset_i, .set_i(set_w), .set_val_i(set_val),
        .w_load_i(w_load_o), .w_data_i(w_data_o), .w_o(w_i));

    always #2 clk_sys_i = ~clk_sys_i;

    task results;
        $display("Compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            results();
        end
    end

    task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task tick;
        @(posedge clk_sys_i);
        #1;
    endtask

    // Each task leaves an idle edge so no strobe is lowered and raised at once
    task setw(input logic [7:0] v);
        set_w = 1'b1;
        set_val = v;
        tick;
        set_w = 1'b0;
        tick;
    endtask

    task ldm(input logic lit, input logic [7:0] v);
        setw(v);
        mode_lit_load_i = lit;
        mode_w_load_i = !lit;
        tick;
        mode_lit_load_i = 1'b0;
        mode_w_load_i = 1'b0;
        tick;
    endtask

    task mv(input int p, input logic [7:0] v, output logic ld, output logic [7:0] d);
        setw(v);
        ctrl_move_i = 1'b1;
        ctrl_port_i = 3'(p);
        tick;
        ctrl_move_i = 1'b0;
        ld = w_load_o;
        d = w_data_o;
        tick;
    endtask

    // one access per call, never back-to-back read-modify-write
    task dacc(input logic wr, input int p, output logic [7:0] d);
        data_wr_i = wr;
        data_rd_i = !wr;
        data_port_i = 3'(p);
        tick;
        data_wr_i = 1'b0;
        data_rd_i = 1'b0;
        d = rd_data_o;
        chk("rd_valid", rd_valid_o, !wr);
        tick;
    endtask

    function automatic logic [7:0] cv(input int k, input int p);
        return 8'h5A ^ {k[2:0], p[2:0], 2'b01};
    endfunction

    // Read every config register of every port under selectors 0Ch..0Fh
    task rdall(input logic wrote);
        logic       ld;
        logic [7:0] d;
        for (int k = 0; k < 4; k++) begin
            ldm(1'b0, 8'(8'h0C + k));
            for (int p = 0; p < 6; p++) begin
                mv(p, 8'h00, ld, d);
                chk("cfg_load", ld, (k != 0 || p != 0) && p < 5);
                if (ld === 1'b1)
                    chk("cfg_value", d, wrote ? cv(k, p) : 8'hFF);
            end
        end
    endtask

    initial begin
        logic       ld;
        logic [7:0] d, st;
        logic [39:0] e_oe, e_pu, e_st, e_tl;
        repeat (8) @(posedge clk_sys_i);
        #1 reset_i = 1'b0;
        chk("mode_reset", mode_o, 5'h1F);
        chk("oe_reset", pin_oe_o, 40'h0);
        chk("pullup_reset", pullup_en_o, 40'h0);
        chk("ttl_reset", level_ttl_o, {40{1'b1}});
        setw(8'hC3);
        dacc(1'b1, 3, d);
        rdall(1'b0);
        // Selector 1Ch..1Fh writes all four config kinds on ports B to E, three on port A
        for (int k = 0; k < 4; k++) begin
            ldm(1'b0, 8'(8'h1C + k));
            for (int p = 0; p < 5; p++)
                mv(p, cv(k, p), ld, d);
        end
        ldm(1'b1, 8'hE3);
        chk("mode_literal", mode_o, 5'h13);
        ldm(1'b0, 8'hEE);
        chk("mode_w", mode_o, 5'h0E);
        ce_i = 1'b0;
        ldm(1'b0, 8'h1F);
        ce_i = 1'b1;
        chk("mode_frozen", mode_o, 5'h0E);
        rdall(1'b1);
        for (int p = 0; p < 5; p++) begin
            st = (p == 0) ? 8'h00 : ~cv(0, p);
            e_oe[p*8 +: 8] = ~cv(3, p);
            e_pu[p*8 +: 8] = ~cv(2, p);
            e_st[p*8 +: 8] = st;
            e_tl[p*8 +: 8] = cv(1, p) & ~st;
        end
        chk("pin_oe", pin_oe_o, e_oe);
        chk("pullup_en", pullup_en_o, e_pu);
        chk("level_ttl", level_ttl_o, e_tl);
        chk("schmitt_en", schmitt_en_o, e_st);
        chk("held_data", pin_out_o[31:24] & pin_oe_o[31:24], 8'hC3 & ~cv(3, 3));
        // settings changed long ago, well past two cycles
        dacc(1'b0, 2, d);
        chk("pin_read", d, 8'h96);
        port_read_source_i = 1'b1;
        dacc(1'b0, 3, d);
        chk("reg_read", d, 8'hC3);
        port_read_source_i = 1'b0;
        ldm(1'b0, 8'h1A);
        mv(1, 8'hFE, ld, d);
        chk("edge_no_load", ld, 1'b0);
        ldm(1'b0, 8'h0B);
        mv(1, 8'hFC, ld, d);
        chk("enable_no_load", ld, 1'b0);
        pin_in_i[9:8] = 2'b11;
        repeat (5) tick;
        chk("pending_set", wakeup_pending_o, 8'h01);
        ldm(1'b0, 8'h19);
        mv(1, 8'h00, ld, d);
        chk("pending_xchg", d, 8'h01);
        chk("pending_clear", wakeup_pending_o, 8'h00);
        ldm(1'b0, 8'h08);
        mv(1, 8'h3E, ld, d);
        chk("cmp_xchg", d, 8'hFF);
        chk("cmp_enable", comparator_enable_o, 1'b1);
        chk("cmp_pin", {pin_oe_o[8], pin_out_o[8]}, 2'b11);
        ldm(1'b0, 8'h18);
        mv(1, 8'hFF, ld, d);
        chk("cmp_xchg_hi", d, 8'h3F);
        chk("cmp_disable", comparator_enable_o, 1'b0);
        // Timer reads on B and C; clear, writes 12h..17h and all port D moves load nothing
        for (int a = 0; a < 8; a++) begin
            for (int p = 1; p < 4; p++) begin
                ldm(1'b0, 8'(a));
                mv(p, 8'h00, ld, d);
                chk("timer_rd_load", ld, p != 3);
                if (p != 3)
                    chk("timer_rd_data", d, 8'h60 | (p == 2 ? 8'h08 : 8'h00) | a);
                ldm(1'b0, (a == 1) ? 8'h10 : 8'(8'h10 + a));
                mv(p, 8'hA5, ld, d);
                chk("timer_wr_load", ld, 1'b0);
            end
        end
        results();
    end
endmodule // pca_top_bench

// ===== pca_top_chk.sv
// Purpose: Port-level checks on selector and control move behaviour
// Assumes: Bound to pca_top, one clock domain
// Notes:   Strobes are pulses, so each answer is pinned to one cycle
`timescale 1ns/1ns
module pca_top_chk (
    input wire        clk_sys_i,
    input wire        reset_i,
    input wire        ce_i,
    input wire        mode_lit_load_i,
    input wire        mode_w_load_i,
    input wire [7:0]  w_i,
    input wire [4:0]  mode_o,
    input wire        ctrl_move_i,
    input wire [2:0]  ctrl_port_i,
    input wire        w_load_o,
    input wire        timer_rd_o,
    input wire        timer_wr_o,
    input wire        timer_clr_o,
    input wire        timer_sel_o,
    input wire [2:0]  timer_addr_o,
    input wire [7:0]  timer_wdata_o,
    input wire        comparator_enable_o,
    input wire [7:0]  wakeup_pending_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // Moves that must hand a value back to W: reads, timer reads, exchanges
    wire mv    = ce_i && ctrl_move_i;
    wire bc    = (ctrl_port_i == 3'h1) || (ctrl_port_i == 3'h2);
    wire cfg   = mode_o[4:2] == 3'h3 && ctrl_port_i <= 3'h4;
    wire rd_ok = mv && ((cfg && !(ctrl_port_i == 3'h0 && mode_o == 5'h0C))
                 || (mode_o[4:3] == 2'h0 && bc)
                 || (mode_o[3:1] == 3'h4 && ctrl_port_i == 3'h1));

    a_mode_reset_val: assert property ($fell(reset_i) |-> mode_o == 5'h1F
        && wakeup_pending_o == 8'h00 && !comparator_enable_o) else $error("reset state wrong");
    a_lit_load_low: assert property (ce_i && mode_lit_load_i && !mode_w_load_i |=>
        mode_o == {$past(mode_o[4]), $past(w_i[3:0])}) else $error("literal load wrong");
    a_w_load_five: assert property (ce_i && mode_w_load_i |=>
        mode_o == $past(w_i[4:0])) else $error("W load of selector wrong");
    a_mode_holds: assert property (!(ce_i && (mode_lit_load_i || mode_w_load_i)) |=>
        $stable(mode_o)) else $error("selector changed without load");
    a_read_loads_w: assert property (rd_ok |=> w_load_o)
        else $error("read move gave no W load");
    a_write_no_load: assert property (mv && !rd_ok |=> !w_load_o)
        else $error("write or unmapped move loaded W");
    a_timer_read: assert property (mv && bc && mode_o <= 5'h07 |-> timer_rd_o
        && timer_sel_o == (ctrl_port_i == 3'h2) && timer_addr_o == mode_o[2:0])
        else $error("timer read strobe wrong");
    a_timer_write: assert property (mv && bc && mode_o >= 5'h12 && mode_o <= 5'h17
        |-> timer_wr_o && timer_sel_o == (ctrl_port_i == 3'h2) && timer_addr_o == mode_o[2:0])
        else $error("timer write strobe wrong");
    a_timer_clear: assert property (mv && bc && mode_o == 5'h10 |-> timer_clr_o
        && !timer_wr_o) else $error("timer clear strobe wrong");
    a_timer_own_port: assert property (!bc |-> !timer_rd_o && !timer_wr_o
        && !timer_clr_o) else $error("timer strobe on wrong port");
    a_timer_wdata_w: assert property (timer_wr_o |-> timer_wdata_o == w_i)
        else $error("timer write data wrong");
endmodule // pca_top_chk

bind pca_top pca_top_chk u_chk (.clk_sys_i, .reset_i, .ce_i, .mode_lit_load_i,
    .mode_w_load_i, .w_i, .mode_o, .ctrl_move_i, .ctrl_port_i, .w_load_o, .timer_rd_o,
    .timer_wr_o, .timer_clr_o, .timer_sel_o, .timer_addr_o, .comparator_enable_o,
    .wakeup_pending_o, .timer_wdata_o);
